// file: hdl/cmd_group_decode.sv
// maps a command code to a group vector of the lock word with at most one bit set
// assumes codes arrive as plain 8-bit values
`timescale 1ns/100ps
module cmd_group_decode
    import wlock_pkg::*;
(
    input wire logic [7:0] code_i,
    output logic [GROUP_COUNT-1:0] group_o
);
    always_comb begin
        group_o = '0;
        case (code_i)
            CMD_VOUT_OV_WARN, CMD_VOUT_UV_WARN, CMD_IOUT_OC_WARN,
            CMD_OT_WARN, CMD_SMBALERT_MASK: group_o[BIT_WARNING] = 1'b1; // see [RL2]
            CMD_IOUT_OC_FAULT, CMD_IOUT_OC_FAULT_RESP, CMD_OT_FAULT,
            CMD_OT_FAULT_RESP, CMD_SIMULATE_FAULTS: group_o[BIT_CUR_TEMP] = 1'b1; // see [RL3]
            CMD_VOUT_MARGIN_HIGH, CMD_VOUT_MARGIN_LOW,
            CMD_VOUT_TRANSITION_RATE: group_o[BIT_TRIM_LEVEL] = 1'b1; // see [RL4]
            CMD_OPERATION: group_o[BIT_RUN_CONTROL] = 1'b1; // see [RL5]
            CMD_FREQUENCY_SWITCH, CMD_INTERLEAVE: group_o[BIT_CONFIG] = 1'b1; // see [RL6]
            CMD_VIN_UV_WARN, CMD_VIN_OV_FAULT, CMD_VIN_OV_WARN,
            CMD_VIN_OV_FAULT_RESP: group_o[BIT_INPUT_VOLT] = 1'b1; // see [RL7]
            CMD_TON_DELAY, CMD_TON_RISE, CMD_TON_MAX_FAULT, CMD_TON_MAX_FAULT_RESP,
            CMD_TOFF_DELAY, CMD_TOFF_FALL, CMD_ON_OFF_CONFIG, CMD_VIN_ON,
            CMD_VIN_OFF: group_o[BIT_STARTUP] = 1'b1; // see [RL8]
            CMD_MFR_ID, CMD_MFR_MODEL, CMD_MFR_REVISION,
            CMD_MFR_SERIAL: group_o[BIT_INVENTORY] = 1'b1; // see [RL9]
            CMD_PIN_DETECT_OVERRIDE, CMD_PMBUS_ADDRESS: group_o[BIT_ADDRESS_PIN] = 1'b1; // see [RL10]
            CMD_UNLOCK_KEY: group_o[BIT_UNLOCK_KEY] = 1'b1; // see [RL11]
            CMD_STORE_USER_ALL: group_o[BIT_NVM_SAVE] = 1'b1; // see [RL14]
            default: begin
                // remaining configuration codes form a contiguous block
                if (code_i >= CMD_CFG_FIRST && code_i <= CMD_CFG_LAST) begin
                    group_o[BIT_CONFIG] = 1'b1; // see [RL6]
                end
            end
        endcase
    end
endmodule : cmd_group_decode

// file: hdl/fine_grain_write_lock.sv
// fine-grain write lock word, platform identity word and write gating
// assumes a pmbus engine presents one word command per req valid pulse,
// and that key, standard-protect and restore state come from sibling blocks
`timescale 1ns/100ps
module fine_grain_write_lock
    import wlock_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire cmd_req_t req_i,
    input wire logic [15:0] nvm_word_i,
    input wire logic nvm_valid_i,
    input wire logic nvm_restore_i,
    input wire logic nvm_store_done_i,
    input wire logic key_nonzero_i,
    input wire logic std_protect_i,
    output cmd_rsp_t rsp_o,
    output logic target_write_o,
    output logic [7:0] target_code_o,
    output logic [15:0] target_data_o,
    output logic [15:0] lock_word_o,
    output logic word_frozen_o,
    output logic key_program_block_o
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        boot_state_t st;
        logic [15:0] lock_word;
        logic save_lock_latched;
        logic frozen;
        cmd_rsp_t rsp;
        logic tgt_write;
        logic [7:0] tgt_code;
        logic [15:0] tgt_data;
        logic key_block;
    } lock_state_t;

    lock_state_t state_reg;
    lock_state_t state_next;
    logic [GROUP_COUNT-1:0] group;
    logic group_locked;
    logic word_locked;
    logic [15:0] wr_val;

    cmd_group_decode u_decode (
        .code_i(req_i.code),
        .group_o(group)
    );

    // ****************************************
    // write gating
    // ****************************************
    always_comb begin
        wr_val = req_i.data & LOCK_WORD_MASK;
        // group bits 10..1 act live; bit 0 uses its boot/restore snapshot
        group_locked = |(group[GROUP_COUNT-1:1] & state_reg.lock_word[GROUP_COUNT-1:1]); // see [RL1]
        if (group[BIT_NVM_SAVE] && (state_reg.save_lock_latched || key_nonzero_i)) begin
            group_locked = 1'b1; // see [RL14]
        end
        // key zero plus bit 1 refuses any new key value
        if (group[BIT_UNLOCK_KEY] && !key_nonzero_i && state_reg.key_block) begin
            group_locked = 1'b1; // see [RL13]
        end
        word_locked = state_reg.lock_word[BIT_SELF_LOCK] || key_nonzero_i
                      || state_reg.frozen; // see [RL11] see [RL18]
        if (req_i.code == CMD_UNLOCK_KEY && state_reg.lock_word[BIT_SELF_LOCK]) begin
            group_locked = 1'b1; // see [RL18]
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        state_next.rsp = '0;
        state_next.tgt_write = 1'b0;
        state_next.key_block = state_reg.lock_word[BIT_UNLOCK_KEY];
        case (state_reg.st)
            ST_BOOT: begin
                if (nvm_valid_i) begin
                    state_next.lock_word = nvm_word_i & LOCK_WORD_MASK; // see [RL19]
                    state_next.save_lock_latched = nvm_word_i[BIT_NVM_SAVE]; // see [RL14]
                    state_next.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (nvm_restore_i) begin
                    state_next.lock_word = nvm_word_i & LOCK_WORD_MASK;
                    state_next.save_lock_latched = nvm_word_i[BIT_NVM_SAVE]; // see [RL14]
                end
                // a store with self-lock, or key lock with bit 1, freezes the word
                if (nvm_store_done_i && (state_reg.lock_word[BIT_SELF_LOCK]
                    || (state_reg.lock_word[BIT_UNLOCK_KEY] && key_nonzero_i))) begin
                    state_next.frozen = 1'b1; // see [RL12] see [RL18]
                end
                if (req_i.valid) begin
                    state_next.rsp.valid = 1'b1;
                    state_next.rsp.accepted = 1'b1;
                    case (req_i.code)
                        CMD_PLATFORM_ID: begin
                            // write accepted and discarded, no comm status raised
                            state_next.rsp.data = PLATFORM_ID_DEFAULT; // see [RL15] see [RL16] see [RL17]
                        end
                        CMD_LOCK_WORD: begin
                            state_next.rsp.data = state_reg.lock_word;
                            if (req_i.write) begin
                                if (word_locked) begin
                                    state_next.rsp.accepted = 1'b0; // see [RL20]
                                end else begin
                                    state_next.lock_word = wr_val; // see [RL19]
                                end
                            end
                        end
                        default: begin
                            state_next.rsp.data = WORD_ZERO;
                            if (req_i.write) begin
                                // clear group bit: standard protect still applies
                                if (group_locked || std_protect_i) begin
                                    state_next.rsp.accepted = 1'b0; // see [RL5] see [RL20]
                                end else begin
                                    state_next.tgt_write = 1'b1;
                                    state_next.tgt_code = req_i.code;
                                    state_next.tgt_data = req_i.data;
                                end
                            end
                        end
                    endcase
                end
            end
            default: begin
                state_next.st = ST_BOOT;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            state_reg <= '0;
            state_reg.st <= ST_BOOT;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rsp_o = state_reg.rsp;
    assign target_write_o = state_reg.tgt_write;
    assign target_code_o = state_reg.tgt_code;
    assign target_data_o = state_reg.tgt_data;
    assign lock_word_o = state_reg.lock_word;
    assign word_frozen_o = state_reg.frozen;
    assign key_program_block_o = state_reg.key_block;
endmodule : fine_grain_write_lock

// file: hdl/wlock_pkg.sv
// constants, field layout and carrier types of the fine-grain write lock
// assumes a word-wide command port fed by an outside pmbus engine
// Notes on behaviour
// [RL1] set group bit makes group read-only
// [RL2] bit 10 locks warning limits, alert mask
// [RL3] bit 9 locks current/temp faults, fault simulation
// [RL4] bit 8 locks margins and transition rate
// [RL5] bit 7 locks operation; clear defers to standard
// [RL6] bit 6 locks configuration commands except on-off config (bit 4)
// [RL7] bit 5 locks input voltage limits, response
// [RL8] bit 4 locks startup/shutdown timing, on-off thresholds
// [RL9] bit 3 locks inventory identity commands
// [RL10] bit 2 locks pin-detect override, bus address
// [RL11] bit 1 locks unlock key; key locks word
// [RL12] bit 1, key nonzero, stored: word locked forever
// [RL13] bit 1, key zero: key programming refused
// [RL14] bit 0 at boot/restore locks nvm save
// [RL15] id word writes accepted, data discarded
// [RL16] id word write sets no comm status
// [RL17] id word reads fixed 16-bit value, no nvm
// [RL18] bit 15 locks word and key; permanent
// [RL19] word at fbh, loaded from nvm at boot
// [RL20] refused write leaves target value unchanged
package wlock_pkg;
    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
    localparam logic [7:0] CMD_SMBALERT_MASK = 8'h1b;
    localparam logic [7:0] CMD_VOUT_TRANSITION_RATE = 8'h27;
    localparam logic [7:0] CMD_FREQUENCY_SWITCH = 8'h33;
    localparam logic [7:0] CMD_VIN_ON = 8'h35;
    localparam logic [7:0] CMD_VIN_OFF = 8'h36;
    localparam logic [7:0] CMD_INTERLEAVE = 8'h37;
    localparam logic [7:0] CMD_VOUT_OV_WARN = 8'h42;
    localparam logic [7:0] CMD_VOUT_UV_WARN = 8'h43;
    localparam logic [7:0] CMD_IOUT_OC_FAULT = 8'h46;
    localparam logic [7:0] CMD_IOUT_OC_FAULT_RESP = 8'h47;
    localparam logic [7:0] CMD_IOUT_OC_WARN = 8'h4a;
    localparam logic [7:0] CMD_OT_FAULT = 8'h4f;
    localparam logic [7:0] CMD_OT_FAULT_RESP = 8'h50;
    localparam logic [7:0] CMD_OT_WARN = 8'h51;
    localparam logic [7:0] CMD_VIN_OV_FAULT = 8'h55;
    localparam logic [7:0] CMD_VIN_OV_FAULT_RESP = 8'h56;
    localparam logic [7:0] CMD_VIN_OV_WARN = 8'h57;
    localparam logic [7:0] CMD_VIN_UV_WARN = 8'h58;
    localparam logic [7:0] CMD_TON_DELAY = 8'h60;
    localparam logic [7:0] CMD_TON_RISE = 8'h61;
    localparam logic [7:0] CMD_TON_MAX_FAULT = 8'h62;
    localparam logic [7:0] CMD_TON_MAX_FAULT_RESP = 8'h63;
    localparam logic [7:0] CMD_TOFF_DELAY = 8'h64;
    localparam logic [7:0] CMD_TOFF_FALL = 8'h65;
    localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
    localparam logic [7:0] CMD_VOUT_MARGIN_HIGH = 8'h25;
    localparam logic [7:0] CMD_VOUT_MARGIN_LOW = 8'h26;
    localparam logic [7:0] CMD_MFR_ID = 8'h99;
    localparam logic [7:0] CMD_MFR_MODEL = 8'h9a;
    localparam logic [7:0] CMD_MFR_REVISION = 8'h9b;
    localparam logic [7:0] CMD_MFR_SERIAL = 8'h9e;
    localparam logic [7:0] CMD_PMBUS_ADDRESS = 8'hd0;
    localparam logic [7:0] CMD_PIN_DETECT_OVERRIDE = 8'hd1;
    localparam logic [7:0] CMD_SIMULATE_FAULTS = 8'he3;
    localparam logic [7:0] CMD_CFG_FIRST = 8'hd2;
    localparam logic [7:0] CMD_CFG_LAST = 8'hdb;
    localparam logic [7:0] CMD_UNLOCK_KEY = 8'hfa;
    localparam logic [7:0] CMD_LOCK_WORD = 8'hfb;
    localparam logic [7:0] CMD_PLATFORM_ID = 8'hfc;

    // ****************************************
    // lock word fields
    // ****************************************
    localparam int BIT_SELF_LOCK = 15;
    localparam int BIT_WARNING = 10;
    localparam int BIT_CUR_TEMP = 9;
    localparam int BIT_TRIM_LEVEL = 8;
    localparam int BIT_RUN_CONTROL = 7;
    localparam int BIT_CONFIG = 6;
    localparam int BIT_INPUT_VOLT = 5;
    localparam int BIT_STARTUP = 4;
    localparam int BIT_INVENTORY = 3;
    localparam int BIT_ADDRESS_PIN = 2;
    localparam int BIT_UNLOCK_KEY = 1;
    localparam int BIT_NVM_SAVE = 0;
    localparam int GROUP_COUNT = 11;
    // bits held here: 15 and 10..0; the rest read as zero
    localparam logic [15:0] LOCK_WORD_MASK = 16'h87ff;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // arbitrary neutral platform identity value
    localparam logic [15:0] PLATFORM_ID_DEFAULT = 16'h5a5a;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_req_t;

    typedef struct packed {
        logic valid;
        logic accepted;
        logic [15:0] data;
    } cmd_rsp_t;

    typedef enum logic [1:0] {
        ST_BOOT,
        ST_RUN
    } boot_state_t;
endpackage : wlock_pkg

// file: verif/fine_grain_write_lock_tb.sv
// self-checking bench for the fine-grain write lock
// assumes package, host model and checker compiled first
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module fine_grain_write_lock_tb
    import wlock_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    cmd_req_t req_i;
    logic [15:0] nvm_word_i = 16'h0000;
    logic nvm_valid_i = 1'b0, nvm_restore_i = 1'b0, nvm_store_done_i = 1'b0;
    logic key_nonzero_i = 1'b0, std_protect_i = 1'b0;
    cmd_rsp_t rsp_o, r;
    logic target_write_o, tw, word_frozen_o, key_program_block_o;
    logic [7:0] target_code_o;
    logic [15:0] target_data_o, lock_word_o;
    int num_errors = 0, tests_run = 0, cyc = 0;
    // rows: command code, guarding bit
    logic [11:0] rows [14] = '{12'h1ba, 12'h51a, 12'he39, 12'h509, 12'h278, 12'h017,
        12'h336, 12'hdb6, 12'h565, 12'h354, 12'h654, 12'h9e3, 12'hd02, 12'hfa1};
    always #12.5 mclk_i = ~mclk_i;
    fine_grain_write_lock DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .req_i(req_i),
        .nvm_word_i(nvm_word_i), .nvm_valid_i(nvm_valid_i), .nvm_restore_i(nvm_restore_i),
        .nvm_store_done_i(nvm_store_done_i), .key_nonzero_i(key_nonzero_i),
        .std_protect_i(std_protect_i), .rsp_o(rsp_o), .target_write_o(target_write_o),
        .target_code_o(target_code_o), .target_data_o(target_data_o),
        .lock_word_o(lock_word_o), .word_frozen_o(word_frozen_o),
        .key_program_block_o(key_program_block_o));
    pm_host u_host (.mclk_i(mclk_i), .rsp_i(rsp_o), .fwd_i(target_write_o), .req_o(req_i));
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d,
        input logic acc, input logic fwd);
        u_host.xfer(w, c, d, r, tw);
        `CHK(r.valid, 1'b1)
        `CHK(r.accepted, acc)
        `CHK(tw, fwd)
    endtask : issue
    // reset low on five sampled edges, then one nvm load pulse
    task automatic boot(input logic [15:0] w);
        @(posedge mclk_i);
        rstn_i <= 1'b0;
        nvm_word_i <= w;
        repeat (4) @(posedge mclk_i);
        #1;
        `CHK(lock_word_o, 16'h0000)
        @(posedge mclk_i);
        rstn_i <= 1'b1;
        nvm_valid_i <= 1'b1;
        @(posedge mclk_i);
        nvm_valid_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask : boot
    task automatic restore(input logic [15:0] w);
        @(posedge mclk_i);
        nvm_word_i <= w;
        nvm_restore_i <= 1'b1;
        @(posedge mclk_i);
        nvm_restore_i <= 1'b0;
    endtask : restore
    task automatic store_pulse();
        @(posedge mclk_i);
        nvm_store_done_i <= 1'b1;
        @(posedge mclk_i);
        nvm_store_done_i <= 1'b0;
    endtask : store_pulse
    initial begin
        boot(16'h0000);
        for (int i = 0; i < 14; i++) begin
            issue(1'b1, CMD_LOCK_WORD, 16'h0001 << rows[i][3:0], 1'b1, 1'b0);
            issue(1'b1, rows[i][11:4], 16'h1234, 1'b0, 1'b0);
            issue(1'b1, CMD_LOCK_WORD, 16'h0000, 1'b1, 1'b0);
            issue(1'b1, rows[i][11:4], 16'h4321, 1'b1, 1'b1);
            `CHK({target_code_o, target_data_o}, {rows[i][11:4], 16'h4321})
        end
        issue(1'b0, CMD_LOCK_WORD, 16'h0000, 1'b1, 1'b0);
        `CHK(r.data, 16'h0000)
        @(posedge mclk_i);
        std_protect_i <= 1'b1;
        issue(1'b1, CMD_OPERATION, 16'h0080, 1'b0, 1'b0);
        @(posedge mclk_i);
        std_protect_i <= 1'b0;
        issue(1'b1, CMD_PLATFORM_ID, 16'h1234, 1'b1, 1'b0);
        issue(1'b0, CMD_PLATFORM_ID, 16'h0000, 1'b1, 1'b0);
        `CHK(r.data, PLATFORM_ID_DEFAULT)
        issue(1'b1, CMD_LOCK_WORD, 16'h0001, 1'b1, 1'b0);
        issue(1'b1, CMD_STORE_USER_ALL, 16'h0000, 1'b1, 1'b1);
        restore(16'h0001);
        issue(1'b1, CMD_STORE_USER_ALL, 16'h0000, 1'b0, 1'b0);
        restore(16'h0000);
        issue(1'b1, CMD_STORE_USER_ALL, 16'h0000, 1'b1, 1'b1);
        issue(1'b1, CMD_LOCK_WORD, 16'h0002, 1'b1, 1'b0);
        @(posedge mclk_i);
        #1;
        `CHK(key_program_block_o, 1'b1)
        @(posedge mclk_i);
        key_nonzero_i <= 1'b1;
        issue(1'b1, CMD_LOCK_WORD, 16'h0000, 1'b0, 1'b0);
        store_pulse();
        key_nonzero_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        `CHK(word_frozen_o, 1'b1)
        issue(1'b1, CMD_LOCK_WORD, 16'h0000, 1'b0, 1'b0);
        boot(16'hffff);
        `CHK(lock_word_o, 16'h87ff)
        issue(1'b1, CMD_LOCK_WORD, 16'h0000, 1'b0, 1'b0);
        // self-lock alone guards the key and freezes the word on store
        boot(16'h8000);
        issue(1'b1, CMD_UNLOCK_KEY, 16'h1234, 1'b0, 1'b0);
        issue(1'b0, CMD_LOCK_WORD, 16'h0000, 1'b1, 1'b0);
        `CHK(r.data, 16'h8000)
        store_pulse();
        @(posedge mclk_i);
        #1;
        `CHK(word_frozen_o, 1'b1)
        finish_test();
    end
endmodule : fine_grain_write_lock_tb
bind fine_grain_write_lock wlock_asserts u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .req_i(req_i), .key_nonzero_i(key_nonzero_i), .rsp_o(rsp_o),
    .target_write_o(target_write_o), .lock_word_o(lock_word_o),
    .word_frozen_o(word_frozen_o), .key_program_block_o(key_program_block_o));

// file: verif/pm_host.sv
// word command host model on the lock block request port
// assumes the block clock, one command at a time
`timescale 1ns/100ps
module pm_host
    import wlock_pkg::*;
(
    input wire logic mclk_i,
    input wire cmd_rsp_t rsp_i,
    input wire logic fwd_i,
    output cmd_req_t req_o
);
    initial req_o = '0;
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
        output cmd_rsp_t r, output logic tw);
        @(posedge mclk_i);
        req_o <= '{valid: 1'b1, write: w, code: c, data: d};
        @(posedge mclk_i);
        // idle bus shows the inverse so stale values never look live
        req_o <= '{valid: 1'b0, write: ~w, code: ~c, data: ~d};
        #1;
        r = rsp_i;
        tw = fwd_i;
    endtask : xfer
endmodule : pm_host

// file: verif/wlock_asserts.sv
// port checker for the fine-grain write lock
// assumes a bind onto fine_grain_write_lock
`timescale 1ns/100ps
module wlock_asserts
    import wlock_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire cmd_req_t req_i,
    input wire logic key_nonzero_i,
    input wire cmd_rsp_t rsp_o,
    input wire logic target_write_o,
    input wire logic [15:0] lock_word_o,
    input wire logic word_frozen_o,
    input wire logic key_program_block_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_wr(logic [7:0] c);
        req_i.valid && req_i.write && req_i.code == c;
    endsequence
    a_rsp_needs_req: assert property (rsp_o.valid |-> $past(req_i.valid))
        else $error("response without request");
    a_fwd_is_accept: assert property (target_write_o |-> rsp_o.accepted)
        else $error("forward without acceptance");
    a_id_write_dropped: assert property (
        s_wr(CMD_PLATFORM_ID) |=> !target_write_o && (!rsp_o.valid || rsp_o.accepted))
        else $error("platform id write mishandled");
    a_id_read_fixed: assert property (
        req_i.valid && !req_i.write && req_i.code == CMD_PLATFORM_ID
        |=> !rsp_o.valid || rsp_o.data == PLATFORM_ID_DEFAULT)
        else $error("platform id read wrong");
    a_run_ctl_locked: assert property (
        s_wr(CMD_OPERATION) ##0 lock_word_o[BIT_RUN_CONTROL] |=> !target_write_o)
        else $error("locked operation forwarded");
    a_key_guards_word: assert property (
        s_wr(CMD_LOCK_WORD) ##0 key_nonzero_i |=> !(rsp_o.valid && rsp_o.accepted))
        else $error("word write taken under key");
    a_bit15_guards: assert property (
        s_wr(CMD_LOCK_WORD) ##0 lock_word_o[BIT_SELF_LOCK] |=> $stable(lock_word_o))
        else $error("self-locked word changed");
    a_frozen_sticky: assert property (word_frozen_o |=> word_frozen_o)
        else $error("freeze dropped");
    a_blk_follows_bit: assert property (
        key_program_block_o == $past(lock_word_o[BIT_UNLOCK_KEY]))
        else $error("key block not tracking bit 1");
    a_unused_zero: assert property (lock_word_o[14:11] == 4'h0)
        else $error("unheld lock bits set");
endmodule : wlock_asserts
